// ===== core/adcs_ctrl.sv
// Control sequencer for a 10-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.svh"

module adcs_ctrl
  import adcs_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int TRIG_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire adcs_apb_req_s i_apb,
  output adcs_apb_rsp_s o_apb,
  input wire logic [TRIG_W-1:0] i_trig_src,
  input wire logic i_global_irq_en,
  input wire logic i_irq_ack,
  input wire adcs_core_rsp_s i_core,
  output adcs_ana_s o_ana,
  output logic o_core_enable,
  output logic o_core_sample,
  output logic o_core_tick,
  output logic o_core_init,
  output logic o_irq
);

  // ------------------------------------------------------------
  // Address decoding
  // ------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  wire logic sel_trig;
  wire logic sel_lo;
  wire logic sel_hi;
  wire logic sel_ctrl;
  wire logic sel_mux;
  wire logic mapped;
  wire logic acc;
  wire logic wr;
  wire logic rd;

  assign sel_trig = hit(i_apb.paddr, `ADCS_IDX_TRIG);
  assign sel_lo = hit(i_apb.paddr, `ADCS_IDX_RES_LO);
  assign sel_hi = hit(i_apb.paddr, `ADCS_IDX_RES_HI);
  assign sel_ctrl = hit(i_apb.paddr, `ADCS_IDX_CTRL);
  assign sel_mux = hit(i_apb.paddr, `ADCS_IDX_MUX);
  assign mapped = sel_trig | sel_lo | sel_hi | sel_ctrl | sel_mux;
  assign acc = i_apb.psel & i_apb.penable;
  assign wr = acc & i_apb.pwrite & i_apb.pstrb[0] & mapped;
  assign rd = acc & ~i_apb.pwrite & mapped;

  wire logic [7:0] wdata;
  assign wdata = i_apb.pwdata[7:0];

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  logic en_q;
  logic ate_q;
  logic ie_q;
  logic flag_q;
  logic [2:0] ps_q;
  logic [7:0] mux_q;
  logic [2:0] trig_sel_q;
  logic [RES_W-1:0] res_q;
  logic lock_q;

  wire logic wr_ctrl;
  wire logic en_d;
  wire logic en_rise;
  wire logic start_wr;
  assign wr_ctrl = wr & sel_ctrl;
  assign en_d = wr_ctrl ? wdata[`ADCS_CTRL_EN] : en_q;
  assign en_rise = en_d & ~en_q;
  assign start_wr = wr_ctrl & wdata[`ADCS_CTRL_START] & en_d;

  wire logic [2:0] ref_reg;
  wire logic [3:0] sel_reg;
  wire logic ladj;
  assign ref_reg = {mux_q[`ADCS_MUX_REF2], mux_q[`ADCS_MUX_REF1],
                    mux_q[`ADCS_MUX_REF0]};
  assign sel_reg = mux_q[`ADCS_MUX_SEL_LO +: 4];
  assign ladj = mux_q[`ADCS_MUX_LADJ];

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  logic [6:0] pre_q;
  wire logic [6:0] pre_top;
  wire logic tick;

  // Codes 000 and 001 both divide by two
  assign pre_top = (ps_q == 3'h0) ? 7'h01 : 7'((8'h01 << ps_q) - 8'h01);
  assign tick = en_q & (pre_q == pre_top);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !en_q) begin
      pre_q <= 7'h00;
    end else if (tick) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // Trigger selection
  // ------------------------------------------------------------
  logic trig_prev_q;
  wire logic trig_now;
  wire logic trig_rise;
  wire logic free_run;

  // Source zero is tied low so selecting it never makes an edge
  assign trig_now = (trig_sel_q == `ADCS_TRIG_FREE) ? 1'b0 : i_trig_src[trig_sel_q];
  assign trig_rise = ate_q & trig_now & ~trig_prev_q;
  assign free_run = ate_q & (trig_sel_q == `ADCS_TRIG_FREE);

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  adcs_state_e state_q;
  logic pend_q;
  logic again_q;
  logic first_q;
  logic refchg_q;
  logic long_q;
  logic [4:0] cyc_q;
  logic [2:0] ref_act_q;
  logic [3:0] sel_act_q;

  wire logic idle;
  wire logic launch;
  wire logic long_d;
  wire logic last_tick;
  wire logic complete;
  assign idle = (state_q == ADCS_IDLE);
  assign launch = idle & en_q & (pend_q | again_q | trig_rise);
  assign long_d = first_q | refchg_q | (ref_reg != ref_act_q);
  assign last_tick = tick &
    (cyc_q == (long_q ? `ADCS_CYC_INIT - 5'h01 : `ADCS_CYC_NORMAL - 5'h01));
  assign complete = (state_q == ADCS_WAIT_CORE) & i_core.done & en_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= ADCS_IDLE;
      cyc_q <= 5'h00;
      long_q <= 1'b0;
    end else if (!en_q) begin
      state_q <= ADCS_IDLE;
      cyc_q <= 5'h00;
    end else begin
      case (state_q)
        ADCS_IDLE: begin
          if (launch) begin
            state_q <= ADCS_RUN;
            cyc_q <= 5'h00;
            long_q <= long_d;
          end
        end
        ADCS_RUN: begin
          if (last_tick) begin
            state_q <= ADCS_WAIT_CORE;
          end else if (tick) begin
            cyc_q <= cyc_q + 5'h01;
          end
        end
        ADCS_WAIT_CORE: begin
          if (complete) begin
            state_q <= ADCS_IDLE;
          end
        end
        default: begin
          state_q <= ADCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pend_q <= 1'b0;
      again_q <= 1'b0;
      first_q <= 1'b0;
      refchg_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_now;
      // Zero written to start is ignored; a start while busy is dropped
      if (!en_d) begin
        pend_q <= 1'b0;
      end else if (start_wr && idle && !launch) begin
        pend_q <= 1'b1;
      end else if (launch) begin
        pend_q <= 1'b0;
      end
      if (!en_q || launch) begin
        again_q <= 1'b0;
      end else if (complete) begin
        again_q <= free_run;
      end
      if (en_rise) begin
        first_q <= 1'b1;
      end else if (launch) begin
        first_q <= 1'b0;
      end
      if (launch) begin
        refchg_q <= 1'b0;
      end else if (idle && (ref_reg != ref_act_q)) begin
        refchg_q <= 1'b1;
      end
    end
  end

  // Channel and reference settings are only followed while idle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ref_act_q <= 3'h0;
      sel_act_q <= 4'h0;
    end else if (idle) begin
      ref_act_q <= ref_reg;
      sel_act_q <= sel_reg;
    end
  end

  // ------------------------------------------------------------
  // Result capture and done flag
  // ------------------------------------------------------------
  wire logic flag_clr;
  assign flag_clr = i_irq_ack | (wr_ctrl & wdata[`ADCS_CTRL_FLAG]);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      res_q <= '0;
      lock_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      if (complete && !lock_q) begin
        res_q <= i_core.result;
      end
      if (rd && sel_lo) begin
        lock_q <= 1'b1;
      end else if (rd && sel_hi) begin
        lock_q <= 1'b0;
      end
      // Completion beats a clear in the same cycle
      if (complete) begin
        flag_q <= 1'b1;
      end else if (flag_clr) begin
        flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      en_q <= 1'(`ADCS_RST_CTRL >> `ADCS_CTRL_EN);
      ate_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= 3'h0;
      mux_q <= `ADCS_RST_MUX;
      trig_sel_q <= `ADCS_RST_TRIG;
    end else begin
      en_q <= en_d;
      if (wr_ctrl) begin
        ate_q <= wdata[`ADCS_CTRL_ATE];
        ie_q <= wdata[`ADCS_CTRL_IE];
        ps_q <= wdata[`ADCS_CTRL_PS_LO +: 3];
      end
      if (wr && sel_mux) begin
        mux_q <= wdata;
      end
      if (wr && sel_trig) begin
        trig_sel_q <= wdata[`ADCS_TRIG_SEL_LO +: 3];
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  wire logic [7:0] res_lo;
  wire logic [7:0] res_hi;
  wire logic [7:0] ctrl_rd;
  wire logic [7:0] rdata;
  assign res_lo = ladj ? {res_q[1:0], 6'h00} : res_q[7:0];
  assign res_hi = ladj ? res_q[9:2] : {6'h00, res_q[9:8]};
  assign ctrl_rd = {en_q, pend_q | ~idle, ate_q, flag_q, ie_q, ps_q};

  assign rdata = sel_ctrl ? ctrl_rd :
                 sel_mux ? mux_q :
                 sel_lo ? res_lo :
                 sel_hi ? res_hi :
                 sel_trig ? {5'h00, trig_sel_q} : 8'h00;

  assign o_apb.pready = 1'b1;
  assign o_apb.prdata = {24'h000000, rdata};
  assign o_apb.pslverr = acc & ~mapped;

  // ------------------------------------------------------------
  // Analog control decode
  // ------------------------------------------------------------
  adcs_ref_e ref_dec;
  always_comb begin
    case (ref_act_q)
      3'h0: ref_dec = ADCS_REF_SUPPLY;
      3'h1: ref_dec = ADCS_REF_EXT_PIN;
      3'h2: ref_dec = ADCS_REF_INT_1V1;
      3'h6: ref_dec = ADCS_REF_INT_2V56;
      3'h7: ref_dec = ADCS_REF_INT_2V56_BYP;
      default: ref_dec = ADCS_REF_RESERVED;
    endcase
  end

  wire logic is_diff;
  assign is_diff = (sel_act_q >= 4'h4) && (sel_act_q <= 4'hB);

  always_comb begin
    o_ana = '0;
    o_ana.ref_sel = ref_dec;
    o_ana.ext_ref_pin = (ref_act_q == 3'h1) | (ref_act_q == 3'h7);
    o_ana.diff_mode = is_diff;
    o_ana.gain_20x = is_diff & sel_act_q[0];
    // Pairs 2-2, 2-3, 0-0, 0-1; 2-2 and 0-0 keep equal sides for offset work
    o_ana.pos_sel = sel_act_q[3] ? 3'h0 : 3'h2;
    o_ana.neg_sel = {~sel_act_q[3], sel_act_q[1]};
    if (!is_diff) begin
      o_ana.neg_sel = 2'h0;
      case (sel_act_q)
        4'h0, 4'h1, 4'h2, 4'h3: o_ana.pos_sel = sel_act_q[2:0];
        4'hC: o_ana.pos_sel = 3'h5;
        4'hD: o_ana.pos_sel = 3'h6;
        4'hF: begin
          o_ana.pos_sel = 3'h4;
          o_ana.temp_sensor_en = 1'b1;
        end
        default: o_ana.pos_sel = 3'h7;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Core handshake and interrupt
  // ------------------------------------------------------------
  assign o_core_enable = en_q;
  assign o_core_sample = launch;
  assign o_core_tick = (state_q == ADCS_RUN) & tick;
  assign o_core_init = en_q & ~idle & long_q;
  assign o_irq = flag_q & ie_q & i_global_irq_en;

endmodule
`default_nettype wire

// ===== core/adcs_defs.svh
// Register indices, field positions, reset values and timing counts
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
`define ADCS_IDX_TRIG 8'h03
`define ADCS_IDX_RES_LO 8'h04
`define ADCS_IDX_RES_HI 8'h05
`define ADCS_IDX_CTRL 8'h06
`define ADCS_IDX_MUX 8'h07
`define ADCS_CTRL_EN 7
`define ADCS_CTRL_START 6
`define ADCS_CTRL_ATE 5
`define ADCS_CTRL_FLAG 4
`define ADCS_CTRL_IE 3
`define ADCS_CTRL_PS_LO 0
`define ADCS_MUX_REF1 7
`define ADCS_MUX_REF0 6
`define ADCS_MUX_LADJ 5
`define ADCS_MUX_REF2 4
`define ADCS_MUX_SEL_LO 0
`define ADCS_TRIG_SEL_LO 0
`define ADCS_RST_CTRL 8'h00
`define ADCS_RST_MUX 8'h00
`define ADCS_RST_TRIG 3'h0
`define ADCS_TRIG_FREE 3'h0
`define ADCS_CYC_NORMAL 5'h0D
`define ADCS_CYC_INIT 5'h19
`endif

// ===== core/adcs_pkg.sv
// Types shared by the converter sequencer and its bench
package adcs_pkg;
  typedef enum logic [2:0] {
    ADCS_REF_SUPPLY, ADCS_REF_EXT_PIN, ADCS_REF_INT_1V1, ADCS_REF_RESERVED,
    ADCS_REF_INT_2V56, ADCS_REF_INT_2V56_BYP
  } adcs_ref_e;
  typedef enum logic [1:0] {ADCS_IDLE, ADCS_RUN, ADCS_WAIT_CORE} adcs_state_e;
  // Positive input: 0..3 pins, 4 temperature sensor, 5 bandgap, 6 ground, 7 none
  typedef struct packed {
    adcs_ref_e ref_sel;
    logic ext_ref_pin;
    logic [2:0] pos_sel;
    logic [1:0] neg_sel;
    logic diff_mode;
    logic gain_20x;
    logic temp_sensor_en;
  } adcs_ana_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } adcs_apb_req_s;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } adcs_apb_rsp_s;
  typedef struct packed {
    logic done;
    logic [9:0] result;
  } adcs_core_rsp_s;
endpackage

// ===== dv/adcs_core_model.sv
// Behavioural converter core that answers the sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_core_model
  import adcs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sample,
  input wire logic i_tick,
  input wire logic i_init,
  input wire logic [9:0] i_value,
  input wire logic [3:0] i_delay,
  output adcs_core_rsp_s o_rsp
);
  logic busy_q;
  logic done_q;
  logic [4:0] tick_q;
  logic [4:0] wait_q;
  // ----------------------------------------
  // Done after the full tick count plus a chosen delay
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_sample) begin
      busy_q <= i_rst_n;
      done_q <= 1'b0;
      tick_q <= 5'h00;
      wait_q <= 5'h00;
    end else if (busy_q) begin
      tick_q <= tick_q + 5'(i_tick);
      if (tick_q == (i_init ? 5'h19 : 5'h0D)) begin
        wait_q <= wait_q + 5'h01;
        busy_q <= wait_q != {1'b0, i_delay};
        done_q <= wait_q == {1'b0, i_delay};
      end
    end else begin
      done_q <= 1'b0;
    end
  end
  // Result outside done shows the inverse, never a stale copy
  assign o_rsp = '{done: done_q, result: done_q ? i_value : ~i_value};
endmodule
`default_nettype wire

// ===== dv/adcs_ctrl_assertions.sv
// Port-level checks of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_ctrl_assertions
  import adcs_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int TRIG_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire adcs_apb_req_s i_apb,
  input wire adcs_apb_rsp_s o_apb,
  input wire logic [TRIG_W-1:0] i_trig_src,
  input wire logic i_global_irq_en,
  input wire logic i_irq_ack,
  input wire adcs_core_rsp_s i_core,
  input wire adcs_ana_s o_ana,
  input wire logic o_core_enable,
  input wire logic o_core_sample,
  input wire logic o_core_tick,
  input wire logic o_core_init,
  input wire logic o_irq
);
  // ----------------------------------------
  // Conversion tracking
  // ----------------------------------------
  logic busy_q;
  logic long_q;
  logic [4:0] tick_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !o_core_enable || i_core.done) busy_q <= 1'b0;
    else if (o_core_sample) busy_q <= 1'b1;
  end
  always_ff @(posedge i_clock) begin
    if (o_core_sample) begin
      tick_q <= 5'h00;
      long_q <= 1'b0;
    end else if (o_core_tick) begin
      tick_q <= tick_q + 5'h01;
      long_q <= long_q | o_core_init;
    end
  end
  sequence s_launch;
    o_core_sample;
  endsequence
  sequence s_first_tick;
    ##[1:260] (o_core_tick || !o_core_enable);
  endsequence
  a_launch_tick: assert property (s_launch |-> s_first_tick)
    else $error("no converter tick after launch");
  a_tick_count: assert property (busy_q && i_core.done |->
    tick_q == (long_q ? `ADCS_CYC_INIT : `ADCS_CYC_NORMAL)) else $error("wrong tick count");
  a_tick_idle: assert property (!busy_q |-> !o_core_tick)
    else $error("tick outside conversion");
  a_sample_idle: assert property (o_core_sample |-> !busy_q)
    else $error("launch while busy");
  a_ana_held: assert property (busy_q && !i_core.done ##1 o_core_enable |-> $stable(o_ana))
    else $error("settings moved mid conversion");
  a_enable_off: assert property (!o_core_enable |-> !o_core_init && !o_core_sample)
    else $error("activity while disabled");
  a_irq_gate: assert property (o_irq |-> i_global_irq_en)
    else $error("irq without global enable");
  a_irq_ack: assert property (i_irq_ack && !i_core.done |=> !o_irq)
    else $error("irq survives ack");
  a_temp_route: assert property (o_ana.temp_sensor_en == (o_ana.pos_sel == 3'h4))
    else $error("sensor enable mismatch");
  a_gain_diff: assert property (o_ana.gain_20x |-> o_ana.diff_mode && !o_ana.pos_sel[0])
    else $error("gain outside pair");
  a_ext_pin: assert property (o_ana.ext_ref_pin ==
    (o_ana.ref_sel inside {ADCS_REF_EXT_PIN, ADCS_REF_INT_2V56_BYP})) else $error("ref pin");
  a_unmapped_err: assert property (i_apb.psel && i_apb.penable &&
    !(i_apb.paddr inside {12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C}) |->
    o_apb.pslverr && o_apb.prdata == 32'h0) else $error("unmapped access accepted");
endmodule
bind adcs_ctrl adcs_ctrl_assertions #(.RES_W(RES_W), .TRIG_W(TRIG_W)) i_adcs_ctrl_assertions (
  .i_clock, .i_rst_n, .i_apb, .o_apb, .i_trig_src, .i_global_irq_en, .i_irq_ack, .i_core,
  .o_ana, .o_core_enable, .o_core_sample, .o_core_tick, .o_core_init, .o_irq);
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.svh"
module testbench
  import adcs_pkg::*;
;
  localparam logic [11:0] TRG = {2'h0, `ADCS_IDX_TRIG, 2'h0};
  localparam logic [11:0] LO = {2'h0, `ADCS_IDX_RES_LO, 2'h0};
  localparam logic [11:0] HI = {2'h0, `ADCS_IDX_RES_HI, 2'h0};
  localparam logic [11:0] CTL = {2'h0, `ADCS_IDX_CTRL, 2'h0};
  localparam logic [11:0] MUX = {2'h0, `ADCS_IDX_MUX, 2'h0};
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  adcs_apb_req_s apb = '0;
  adcs_apb_rsp_s o_apb;
  adcs_core_rsp_s core;
  adcs_ana_s ana;
  logic [7:0] trg = 8'h00;
  logic glob = 1'b0;
  logic ack = 1'b0;
  logic en, smp, tick, init, irq;
  logic [9:0] val = 10'h000;
  logic [3:0] dly = 4'h0;
  logic [7:0] mux_v = 8'h00;
  logic [7:0] exp_q[$];
  logic [11:0] ad[6] = '{TRG, LO, HI, CTL, MUX, 12'h020};
  logic [2:0] rt[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  int fails = 0, samples_checked = 0, per = 2, tcnt = 0, gap = 0, nsmp = 0, cyc = 0;
  always #2.5 i_clock = ~i_clock;
  adcs_ctrl i_adcs_ctrl (.i_clock, .i_rst_n, .i_apb(apb), .o_apb, .i_trig_src(trg),
    .i_global_irq_en(glob), .i_irq_ack(ack), .i_core(core), .o_ana(ana), .o_core_enable(en),
    .o_core_sample(smp), .o_core_tick(tick), .o_core_init(init), .o_irq(irq));
  adcs_core_model i_adcs_core_model (.i_clock, .i_rst_n, .i_sample(smp), .i_tick(tick),
    .i_init(init), .i_value(val), .i_delay(dly), .o_rsp(core));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    apb <= '{1'b1, 1'b0, w, a, {24'h0, d}, 4'hF};
    @(posedge i_clock);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_apb.pready !== 1'b1);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic go(input logic [2:0] d);
    per = d < 3'h2 ? 2 : 1 << d;
    val <= 10'($urandom);
    dly <= 4'($urandom);
    wr(CTL, {5'h1B, d});
  endtask
  task automatic fin(input logic [7:0] c, input int nt);
    while (core.done !== 1'b1) begin
      @(posedge i_clock);
    end
    @(posedge i_clock);
    chk("ticks", nt, tcnt);
    chk("irq", glob, irq);
    rd(CTL, c);
    rd(LO, val[7:0]);
    rd(HI, {6'h0, val[9:8]});
    wr(MUX, mux_v | 8'h20);
    rd(LO, {val[1:0], 6'h0});
    rd(HI, val[9:2]);
    wr(MUX, mux_v);
    ack <= 1'b1;
    @(posedge i_clock);
    ack <= 1'b0;
    rd(CTL, c & 8'hEF);
  endtask
  // Read watcher and converter clock watcher
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 60000) begin
      fails++;
      end_sim();
    end
    if (apb.psel && apb.penable && o_apb.pready === 1'b1 && !apb.pwrite)
      chk("prdata", {24'h0, exp_q.pop_front()}, o_apb.prdata);
    if (smp === 1'b1) begin
      tcnt = 0;
      nsmp++;
    end
    if (tick === 1'b1) begin
      if (tcnt > 0) chk("tick_gap", per, gap);
      tcnt++;
      gap = 0;
    end
    gap++;
  end
  initial begin
    logic [2:0] r;
    logic [9:0] v;
    adcs_ana_s e;
    int n0, k;
    void'($urandom(32'h8FFD));
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wr(12'h020, 8'hFF);
    wr(LO, 8'hFF);
    foreach (ad[j]) rd(ad[j], 8'h00);
    for (int i = 0; i < 16; i++) begin
      r = rt[i % 6];
      wr(MUX, {r[1], r[0], 1'b0, r[2], 4'(i)});
      repeat (2) @(posedge i_clock);
      e.ref_sel = adcs_ref_e'(r < 3'h6 ? r : r - 3'h2);
      e.ext_ref_pin = r == 3'h1 || r == 3'h7;
      e.diff_mode = i inside {[4:11]};
      e.pos_sel = i < 4 ? 3'(i) : i < 8 ? 3'h2 : i < 12 ? 3'h0 : 3'(i - 7) & 3'h7;
      if (i == 15) e.pos_sel = 3'h4;
      e.neg_sel = e.diff_mode ? {i < 8, i[1]} : 2'h0;
      e.gain_20x = e.diff_mode & i[0];
      e.temp_sensor_en = i == 15;
      chk("ana", e, ana);
    end
    wr(MUX, 8'h00);
    for (int i = 0; i < 9; i++) begin
      glob <= i[0];
      go(i[2:0]);
      fin({5'h13, i[2:0]}, i == 0 ? 25 : 13);
    end
    go(3'h7);
    rd(CTL, 8'hCF);
    wr(CTL, 8'h8F);
    rd(CTL, 8'hCF);
    mux_v = 8'h4F;
    wr(MUX, mux_v);
    chk("pos_held", 3'h0, ana.pos_sel);
    chk("ref_held", ADCS_REF_SUPPLY, ana.ref_sel);
    fin(8'h9F, 13);
    chk("pos_new", 3'h4, ana.pos_sel);
    go(3'h2);
    fin(8'h9A, 25);
    go(3'h7);
    wr(CTL, 8'h08);
    repeat (300) @(posedge i_clock);
    rd(CTL, 8'h08);
    go(3'h1);
    fin(8'h99, 25);
    wr(TRG, 8'h02);
    wr(CTL, 8'hBA);
    per = 4;
    val <= 10'($urandom);
    trg[2] <= 1'b1;
    fin(8'hBA, 13);
    n0 = nsmp;
    trg <= 8'h01;
    wr(TRG, 8'h00);
    repeat (20) @(posedge i_clock);
    chk("trig_free", n0, nsmp);
    wr(CTL, 8'hEA);
    k = 0;
    while (nsmp < n0 + 3 && k < 2000) begin
      @(posedge i_clock);
      k++;
    end
    chk("free_run", n0 + 3, nsmp);
    rd(LO, val[7:0]);
    v = val;
    val <= ~val;
    k = nsmp;
    wait (nsmp >= k + 2);
    rd(HI, {6'h0, v[9:8]});
    k = nsmp;
    wait (nsmp >= k + 2);
    rd(HI, {6'h0, ~v[9:8]});
    wr(CTL, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
